// file: src/msfg_top.sv
// mono amplifier channel select, modulator timing, faults, gain and apb registers
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "msfg_defs.svh"
module msfg_top
	import msfg_pkg::*;
#(
	parameter int DATA_W = 24,  // audio word width
	parameter int PW     = 4,   // modulator step bits per switching period
	parameter int CNT_W  = 20   // frame period counter width
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [7:0]        paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              channel_pick,
	input  wire logic              word_valid,
	input  wire logic              word_first,
	input  wire logic [DATA_W-1:0] word_data,
	input  wire logic              short_detect,
	input  wire logic              over_temp,
	input  wire logic              temp_cooled,
	input  wire logic              shutdown_n,
	input  wire logic              gain_select_high_bit,
	input  wire logic              gain_select_low_bit,
	output logic                   positive_bridge_output,
	output logic                   negative_bridge_output,
	output logic                   output_drive_en,
	output logic                   low_power_state,
	output logic      [7:0]        gain_db_tenths,
	output logic                   gain_reserved,
	output logic                   irq
);

	// ==========================================================
	// state
	typedef struct packed {
		msfg_state_t                st;          // amplifier state
		logic                       mute;        // software soft mute
		logic [`MSFG_IRQ_W-1:0]     irq_stat;    // sticky events
		logic [`MSFG_IRQ_W-1:0]     irq_en;      // event enables
		logic                       irq;         // interrupt level
		logic [31:0]                prdata;      // read data
		logic                       pready;      // access done
		logic                       pslverr;     // unmapped access
		logic [DATA_W-1:0]          left;        // held left word
		logic                       have_left;   // left word waiting
		logic [DATA_W-1:0]          mono;        // selected sample
		logic [CNT_W-1:0]           frame_cnt;   // cycles since frame start
		logic [CNT_W-1:0]           frame_len;   // last frame length
		logic [CNT_W-1:0]           div_cnt;     // step divider
		logic                       step_tick;   // modulator step enable
		logic                       drive_en;    // bridge drive allowed
		logic                       low_power;   // shutdown pin state
		logic [7:0]                 gain;        // decoded gain
		logic                       gain_resv;   // reserved gain code
	} msfg_top_st_t;

	msfg_top_st_t r_reg;   // registered state
	msfg_top_st_t r_next;  // next state

	logic [3:0] sync_v;    // synchronised fault and shutdown levels
	logic       s_short;   // short detected
	logic       s_hot;     // die above trip point
	logic       s_cool;    // die cooled below release point
	logic       s_shdn_n;  // shutdown pin, high runs

	// ==========================================================
	// input synchronisers
	// fault inputs synchronised
	msfg_sync #(
		.W(4)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({shutdown_n, temp_cooled, over_temp, short_detect}),
		.sync_out (sync_v)
	);

	assign s_short  = sync_v[0];
	assign s_hot    = sync_v[1];
	assign s_cool   = sync_v[2];
	assign s_shdn_n = sync_v[3];

	// ==========================================================
	// next state logic
	always_comb begin
		logic [`MSFG_IRQ_W-1:0] ev;       // events this cycle
		logic [`MSFG_IRQ_W-1:0] clr;      // software clear this cycle
		logic [CNT_W-1:0]       step_len; // cycles per modulator step
		logic                   acc;      // apb access phase
		r_next  = r_reg;
		ev      = '0;
		clr     = '0;
		step_len = '0;
		acc     = psel && penable && !r_reg.pready;

		// ------------------------------------------------------
		// apb slave: answer one cycle into the access phase
		r_next.pready  = 1'b0;
		r_next.pslverr = 1'b0;
		if (acc) begin
			r_next.pready = 1'b1;
			r_next.prdata = '0;
			case (paddr)
				`MSFG_OFF_CTRL: begin
					if (pwrite) begin
						r_next.mute = pwdata[`MSFG_CTRL_MUTE];
					end
					r_next.prdata[`MSFG_CTRL_MUTE] = r_reg.mute;
				end
				`MSFG_OFF_STATUS: begin
					r_next.prdata[`MSFG_ST_STATE_LO +: 2] = r_reg.st;
					r_next.prdata[`MSFG_ST_SHORT] = (r_reg.st == MSFG_SHORT);
					r_next.prdata[`MSFG_ST_HOT]   = (r_reg.st == MSFG_HOT);
					r_next.prdata[`MSFG_ST_SHDN]  = r_reg.low_power;
					r_next.prdata[`MSFG_ST_RESV]  = r_reg.gain_resv;
					r_next.prdata[`MSFG_ST_GAIN_LO +: 8] = r_reg.gain;
				end
				`MSFG_OFF_IRQ_STAT: begin
					r_next.prdata[`MSFG_IRQ_W-1:0] = r_reg.irq_stat;
				end
				`MSFG_OFF_IRQ_EN: begin
					if (pwrite) begin
						r_next.irq_en = pwdata[`MSFG_IRQ_W-1:0];
					end
					r_next.prdata[`MSFG_IRQ_W-1:0] = r_reg.irq_en;
				end
				`MSFG_OFF_IRQ_CLR: begin
					// write-only, reads as zero
					if (pwrite) begin
						clr = pwdata[`MSFG_IRQ_W-1:0];
					end
				end
				`MSFG_OFF_MONO: begin
					r_next.prdata[DATA_W-1:0] = r_reg.mono;
				end
				default: begin
					// unmapped: error, no effect
					r_next.pslverr = 1'b1;
				end
			endcase
		end

		// ------------------------------------------------------
		// frame capture and channel pick
		if (word_valid) begin
			if (word_first) begin
				r_next.left      = word_data;
				r_next.have_left = 1'b1;
			end else if (r_reg.have_left) begin
				r_next.have_left = 1'b0;
				r_next.mono = channel_pick ? r_reg.left : word_data;
			end
		end

		// ------------------------------------------------------
		// frame length measurement, saturating
		if (r_reg.frame_cnt != '1) begin
			r_next.frame_cnt = r_reg.frame_cnt + 1'b1;
		end
		if (word_valid && word_first) begin
			r_next.frame_len = r_reg.frame_cnt;
			// this cycle is the first of the new frame, so count from one
			r_next.frame_cnt = {{(CNT_W-1){1'b0}}, 1'b1};
		end

		// ------------------------------------------------------
		// 64 periods per frame
		step_len = r_reg.frame_len >> (`MSFG_OSR_SHIFT + PW);
		r_next.step_tick = 1'b0;
		if ((r_reg.div_cnt + 1'b1) >= step_len) begin
			// shortest step is one cycle
			r_next.div_cnt   = '0;
			r_next.step_tick = 1'b1;
		end else begin
			r_next.div_cnt = r_reg.div_cnt + 1'b1;
		end

		// ------------------------------------------------------
		// amplifier state machine
		case (r_reg.st)
			MSFG_SHDN: begin
				if (s_shdn_n) begin
					r_next.st = MSFG_RUN;
				end
			end
			MSFG_RUN: begin
				if (s_short) begin
					r_next.st = MSFG_SHORT;
					ev[`MSFG_IRQ_SHORT] = 1'b1;
				end else if (s_hot) begin
					r_next.st = MSFG_HOT;
					ev[`MSFG_IRQ_HOT] = 1'b1;
				end
			end
			MSFG_HOT: begin
				if (s_short) begin
					r_next.st = MSFG_SHORT;
					ev[`MSFG_IRQ_SHORT] = 1'b1;
				end else if (s_cool && !s_hot) begin
					r_next.st = MSFG_RUN;
					ev[`MSFG_IRQ_COOL] = 1'b1;
				end
			end
			MSFG_SHORT: begin
				r_next.st = MSFG_SHORT;
			end
			default: begin
				r_next.st = MSFG_SHDN;
			end
		endcase
		if (!s_shdn_n) begin
			r_next.st = MSFG_SHDN;
		end
		r_next.drive_en  = (r_next.st == MSFG_RUN) && !s_short;
		r_next.low_power = !s_shdn_n;

		// ------------------------------------------------------
		// interrupts: event set wins over clear
		r_next.irq_stat = (r_reg.irq_stat & ~clr) | ev;
		r_next.irq      = |(r_next.irq_stat & r_next.irq_en);

		// ------------------------------------------------------
		// gain pin decode
		r_next.gain_resv = 1'b0;
		case ({gain_select_high_bit, gain_select_low_bit})
			2'h0: r_next.gain = `MSFG_GAIN_12DB;
			2'h1: r_next.gain = `MSFG_GAIN_18DB;
			2'h2: r_next.gain = `MSFG_GAIN_236DB;
			default: begin
				r_next.gain      = `MSFG_GAIN_RESV;
				r_next.gain_resv = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// register the state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg           <= '0;
			r_reg.st        <= MSFG_SHDN;
			r_reg.mute      <= `MSFG_RST_MUTE;
			r_reg.irq_stat  <= `MSFG_RST_IRQ;
			r_reg.irq_en    <= `MSFG_RST_IRQ;
			r_reg.low_power <= 1'b1;
			r_reg.gain      <= `MSFG_GAIN_12DB;
		end else begin
			r_reg <= r_next;
		end
	end

	// ==========================================================
	// bridge modulator, idle when muted or not running
	msfg_pwm #(
		.PW(PW)
	) u_pwm (
		.pclk      (pclk),
		.presetn   (presetn),
		.step_tick (r_reg.step_tick),
		.run       (r_reg.drive_en && !r_reg.mute),
		.duty      (r_reg.mono[DATA_W-1 -: PW]),
		.pos_out   (positive_bridge_output),
		.neg_out   (negative_bridge_output)
	);

	// ==========================================================
	// outputs, all from flops
	assign prdata          = r_reg.prdata;
	assign pready          = r_reg.pready;
	assign pslverr         = r_reg.pslverr;
	assign output_drive_en = r_reg.drive_en;
	assign low_power_state = r_reg.low_power;
	assign gain_db_tenths  = r_reg.gain;
	assign gain_reserved   = r_reg.gain_resv;
	assign irq             = r_reg.irq;
endmodule : msfg_top

// file: pkg/msfg_defs.svh
// constants of the mono amplifier select, fault and gain control block
// Function
// - pick low selects right, high selects left
// - first word of frame is left
// - oversampling fixed at 64x, chosen automatically
// - zero input keeps both bridge outputs in phase
// - positive value: positive output over half duty
// - negative value: negative output over half duty
// - output short disables drive, enters shutdown
// - short stays latched until shutdown pin cycles
// - after clearing, run; persistent short retrips
// - over-temperature indication forces shutdown, outputs off
// - thermal fault self-clears after cooling fifteen degrees
// - gain pins decode 12, 18, 23.6 dB, reserved
// - shutdown pin low mutes, enters low current
`ifndef MSFG_DEFS_SVH
`define MSFG_DEFS_SVH

// ==========================================================
// register map (byte addresses)
`define MSFG_OFF_CTRL      8'h00
`define MSFG_OFF_STATUS    8'h04
`define MSFG_OFF_IRQ_STAT  8'h08
`define MSFG_OFF_IRQ_EN    8'h0C
`define MSFG_OFF_IRQ_CLR   8'h10
`define MSFG_OFF_MONO      8'h14

// ==========================================================
// field positions
`define MSFG_CTRL_MUTE     0
`define MSFG_ST_STATE_LO   0
`define MSFG_ST_SHORT      2
`define MSFG_ST_HOT        3
`define MSFG_ST_SHDN       4
`define MSFG_ST_RESV       5
`define MSFG_ST_GAIN_LO    8
`define MSFG_IRQ_W         3
`define MSFG_IRQ_SHORT     0
`define MSFG_IRQ_HOT       1
`define MSFG_IRQ_COOL      2

// ==========================================================
// reset values
`define MSFG_RST_IRQ       3'h0
`define MSFG_RST_MUTE      1'b0

// ==========================================================
// oversampling and gain codes
`define MSFG_OSR_SHIFT     6
`define MSFG_GAIN_12DB     8'h78
`define MSFG_GAIN_18DB     8'hB4
`define MSFG_GAIN_236DB    8'hEC
`define MSFG_GAIN_RESV     8'h00

`endif

// file: pkg/msfg_pkg.sv
// types shared by the mono amplifier control block
package msfg_pkg;
	// amplifier state, gray coded along shutdown, run, hot, short
	typedef enum logic [1:0] {
		MSFG_SHDN  = 2'h0,
		MSFG_RUN   = 2'h1,
		MSFG_HOT   = 2'h3,
		MSFG_SHORT = 2'h2
	} msfg_state_t;
endpackage : msfg_pkg

// file: src/msfg_sync.sv
// two flip-flop synchroniser for a group of level inputs
`timescale 1ns/100ps
module msfg_sync #(
	parameter int W = 4
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	import msfg_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		logic [W-1:0] meta;   // first stage, read only by second
		logic [W-1:0] safe;   // second stage
	} msfg_sync_st_t;

	msfg_sync_st_t r_reg;   // registered state
	msfg_sync_st_t r_next;  // next state

	// shift each bit through two stages
	always_comb begin
		r_next = r_reg;
		for (int i = 0; i < W; i++) begin
			r_next.meta[i] = async_in[i];
			r_next.safe[i] = r_reg.meta[i];
		end
	end

	// register the state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign sync_out = r_reg.safe;
endmodule : msfg_sync

// file: src/msfg_pwm.sv
// in-phase bridge modulator driven by a step enable
`timescale 1ns/100ps
module msfg_pwm #(
	parameter int PW = 4
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          step_tick,
	input  wire logic          run,
	input  wire logic [PW-1:0] duty,
	output logic               pos_out,
	output logic               neg_out
);
	import msfg_pkg::*;

	// two guard bits so half minus the most negative value cannot wrap
	localparam logic signed [PW+1:0] HALF = (PW+2)'(1 << (PW-1)); // half period

	// ==========================================================
	// state
	typedef struct packed {
		logic [PW-1:0] step;  // position in switching period
		logic [PW-1:0] held;  // duty held for whole period
		logic          pos;   // positive bridge drive
		logic          neg;   // negative bridge drive
	} msfg_pwm_st_t;

	msfg_pwm_st_t r_reg;   // registered state
	msfg_pwm_st_t r_next;  // next state

	// compare period position against half plus and minus the value
	always_comb begin
		logic signed [PW+1:0] d;
		logic signed [PW+1:0] s;
		r_next = r_reg;
		d = $signed({{2{r_reg.held[PW-1]}}, r_reg.held});
		s = $signed({2'b00, r_reg.step});
		if (step_tick) begin
			r_next.step = r_reg.step + 1'b1;
			// new duty only at period start, no mid-period glitch
			if (r_reg.step == '1) begin
				r_next.held = duty;
			end
		end
		if (run) begin
			r_next.pos = (s < (HALF + d));
			r_next.neg = (s < (HALF - d));
		end else begin
			// both low: no drive
			r_next.pos = 1'b0;
			r_next.neg = 1'b0;
		end
	end

	// register the state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign pos_out = r_reg.pos;
	assign neg_out = r_reg.neg;
endmodule : msfg_pwm

// file: verification/msfg_assertions.sv
// concurrent checks on fault, shutdown and gain behaviour of the control block
`timescale 1ns/100ps
module msfg_assertions (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       short_detect,
	input wire logic       over_temp,
	input wire logic       temp_cooled,
	input wire logic       shutdown_n,
	input wire logic       gain_select_high_bit,
	input wire logic       gain_select_low_bit,
	input wire logic       positive_bridge_output,
	input wire logic       negative_bridge_output,
	input wire logic       output_drive_en,
	input wire logic       low_power_state,
	input wire logic [7:0] gain_db_tenths,
	input wire logic       gain_reserved
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [2:0] short_hist_reg;  // last three short samples
	logic       short_latch_reg; // short seen, shutdown not yet cycled
	logic [8:0] gain_exp;        // expected {reserved, tenths of dB}
	// ==========================================================
	// shadow of the short latch, cleared early so it never outlives the design's
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			short_hist_reg  <= 3'h0;
			short_latch_reg <= 1'b0;
		end else begin
			short_hist_reg  <= {short_hist_reg[1:0], short_detect};
			short_latch_reg <= shutdown_n & (short_latch_reg | (&short_hist_reg));
		end
	end
	assign gain_exp = gain_select_high_bit ? (gain_select_low_bit ? 9'h100 : 9'h0EC)
		: (gain_select_low_bit ? 9'h0B4 : 9'h078);
	// ==========================================================
	// properties
	// bridge goes quiet
	property p_short_quiet;
		short_detect [*6] |-> !positive_bridge_output && !negative_bridge_output;
	endproperty
	a_short_quiet: assert property (p_short_quiet)
		else $error("bridge still switching during a short");
	property p_short_held;
		short_latch_reg |-> !output_drive_en;
	endproperty
	a_short_held: assert property (p_short_held)
		else $error("drive back on before shutdown was cycled");
	property p_resume;
		$rose(shutdown_n) ##1 (shutdown_n && !short_detect && !over_temp) [*7]
			|-> output_drive_en;
	endproperty
	a_resume: assert property (p_resume)
		else $error("drive not resumed after shutdown cycle");
	property p_hot_off;
		over_temp [*5] |-> !output_drive_en;
	endproperty
	a_hot_off: assert property (p_hot_off)
		else $error("drive on while over temperature");
	property p_cool_on;
		(temp_cooled && !over_temp && shutdown_n && !short_detect && !short_latch_reg) [*8]
			|-> output_drive_en;
	endproperty
	a_cool_on: assert property (p_cool_on)
		else $error("drive not resumed after cooling");
	property p_gain;
		$stable({gain_select_high_bit, gain_select_low_bit}) [*2]
			|-> {gain_reserved, gain_db_tenths} == gain_exp;
	endproperty
	a_gain: assert property (p_gain)
		else $error("gain code decoded wrongly");
	property p_shdn;
		!shutdown_n [*4] |-> low_power_state && !output_drive_en;
	endproperty
	a_shdn: assert property (p_shdn)
		else $error("shutdown pin low but block still active");
	property p_sync;
		(output_drive_en && !short_detect && !over_temp && shutdown_n) ##1 short_detect
			|=> output_drive_en;
	endproperty
	a_sync: assert property (p_sync)
		else $error("short acted without synchroniser delay");
	// ==========================================================
	// main scenarios reached
	c_short: cover property (short_latch_reg);
	c_cool: cover property (over_temp ##[1:20] (!over_temp && output_drive_en));
	c_resv: cover property (gain_reserved);
endmodule : msfg_assertions
bind msfg_top msfg_assertions u_msfg_chk (.*);

// file: verification/msfg_partner.sv
// audio source model: one left word then one right word per frame
`timescale 1ns/100ps
module msfg_partner #(
	parameter int FRAME = 2048 // pclk cycles per frame
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [23:0] sample_l,
	input  wire logic [23:0] sample_r,
	output logic             word_valid,
	output logic             word_first,
	output logic [23:0]      word_data
);
	int t; // position in the frame
	// ==========================================================
	// frame generator; data toggles between words so a stale word never looks valid
	// left word first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t          <= 0;
			word_valid <= 1'b0;
			word_first <= 1'b0;
			word_data  <= 24'h000000;
		end else begin
			t          <= (t == FRAME - 1) ? 0 : t + 1;
			word_valid <= (t == 0) || (t == FRAME / 2);
			word_first <= (t == 0);
			if (t == 0) begin
				word_data <= sample_l;
			end else if (t == FRAME / 2) begin
				word_data <= sample_r;
			end else begin
				word_data <= ~word_data;
			end
		end
	end
endmodule : msfg_partner

// file: verification/tb.sv
// self-checking bench of the mono amplifier control block
`timescale 1ns/100ps
module tb;
	import msfg_pkg::*;
	localparam int FRAME = 2048;                // pclk cycles per audio frame
	localparam int PER   = 16 * (FRAME >> 10);  // switching period in cycles
	localparam int LIMIT = 40000;               // cycle ceiling of the run
	localparam logic [8:0] GAIN_EXP [4] = '{9'h078, 9'h0B4, 9'h0EC, 9'h100};
	localparam int DUTY [3] = '{0, 5, -6};      // signed top nibbles
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, gain_db_tenths;
	logic [31:0] pwdata = 32'h00000000, prdata;
	logic        pready, pslverr, word_valid, word_first, irq;
	logic [23:0] word_data, sample_l = 24'h000000, sample_r = 24'h000000;
	logic        channel_pick = 1'b0, short_detect = 1'b0, over_temp = 1'b0, temp_cooled = 1'b0;
	logic        shutdown_n = 1'b1, gain_select_high_bit = 1'b0, gain_select_low_bit = 1'b0;
	logic        positive_bridge_output, negative_bridge_output, output_drive_en;
	logic        low_power_state, gain_reserved;
	logic [32:0] exp_q[$];                      // expected {pslverr, prdata}
	int          n_fail = 0, checked = 0, cyc = 0;
	logic [31:0] rng = 32'h0000ECB0;            // xorshift state
	msfg_top DUT (.*);
	msfg_partner #(.FRAME(FRAME)) u_src (.*);
	always #2 pclk = ~pclk;
	// ==========================================================
	// helpers
	function automatic logic [23:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng[23:0];
	endfunction : rnd
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic cycles(input int n);
		repeat (n) @(posedge pclk);
	endtask : cycles
	// apb transfer; reads leave their expected answer in the queue
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
		@(posedge pclk);
		psel   <= 1'b1;
		paddr  <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		if (!w) exp_q.push_back(e);
		do @(posedge pclk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// count high cycles of both bridge outputs over ten periods
	task automatic duty(input int d);
		logic [15:0] p, n, x, rs;  // rs: rising edges of the positive output
		logic        v;            // previous positive output
		p = 16'h0000;
		n = 16'h0000;
		x = 16'h0000;
		rs = 16'h0000;
		v = positive_bridge_output;
		repeat (10 * PER) begin
			@(posedge pclk);
			rs += positive_bridge_output & ~v;
			v = positive_bridge_output;
			p += positive_bridge_output;
			n += negative_bridge_output;
			x += positive_bridge_output ^ negative_bridge_output;
		end
		chk(p, (8 + d) * 10 * PER / 16);
		chk(n, (8 - d) * 10 * PER / 16);
		chk(x, (d < 0 ? -d : d) * 20 * PER / 16);
		chk(rs, 10 * PER * 64 / FRAME);
	endtask : duty
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop
	// ==========================================================
	// read monitor and hang guard
	always @(posedge pclk) begin
		cyc++;
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_q.size() == 0) begin
				n_fail++;
				$display("BAD t=%0t got=%h exp=%h", $time, {pslverr, prdata}, 33'h0);
			end else begin
				chk({pslverr, prdata}, exp_q.pop_front());
			end
		end
		if (cyc == LIMIT) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, cyc, LIMIT);
			report_and_stop();
		end
	end
	// ==========================================================
	// main sequence
	initial begin
		logic [23:0] r;
		cycles(12);
		presetn <= 1'b1;
		apb(8'h08, 1'b0, 32'h0, 33'h0);
		apb(8'h0C, 1'b0, 32'h0, 33'h0);
		apb(8'h40, 1'b0, 32'h0, {1'b1, 32'h0});
		apb(8'h0C, 1'b1, 32'h7, 33'h0);
		// soft mute: read back, bridge quiet, then release
		apb(8'h00, 1'b1, 32'h1, 33'h0);
		apb(8'h00, 1'b0, 32'h0, 33'h1);
		chk(positive_bridge_output | negative_bridge_output, 1'b0);
		apb(8'h00, 1'b1, 32'h0, 33'h0);
		$display("end of register test");
		for (int i = 0; i < 4; i++) begin
			{gain_select_high_bit, gain_select_low_bit} <= i[1:0];
			cycles(3);
			chk({gain_reserved, gain_db_tenths}, GAIN_EXP[i]);
		end
		{gain_select_high_bit, gain_select_low_bit} <= 2'h0;
		$display("end of gain test");
		for (int i = 0; i < 2; i++) begin
			channel_pick <= i[0];
			sample_l     <= rnd() & 24'h7FFFFF;
			sample_r     <= rnd() & 24'h7FFFFF;
			cycles(2 * FRAME);
			apb(8'h14, 1'b0, 32'h0, {9'h000, i[0] ? sample_l : sample_r});
		end
		for (int i = 0; i < 3; i++) begin
			r = rnd();
			sample_l <= {DUTY[i][3:0], r[19:0]};
			sample_r <= {DUTY[i][3:0], r[19:0]};
			cycles(2 * FRAME);
			duty(DUTY[i]);
		end
		$display("end of audio test");
		short_detect <= 1'b1;
		cycles(8);
		chk(output_drive_en, 1'b0);
		apb(8'h04, 1'b0, 32'h0, 33'h000007806);
		chk(irq, 1'b1);
		shutdown_n <= 1'b0;
		cycles(8);
		chk(low_power_state, 1'b1);
		shutdown_n <= 1'b1;
		cycles(20);
		chk(output_drive_en, 1'b0);
		short_detect <= 1'b0;
		cycles(20);
		chk(output_drive_en, 1'b0);
		shutdown_n <= 1'b0;
		cycles(8);
		shutdown_n <= 1'b1;
		cycles(8);
		chk(output_drive_en, 1'b1);
		apb(8'h10, 1'b1, 32'h7, 33'h0);
		cycles(2);
		chk(irq, 1'b0);
		$display("end of short test");
		over_temp <= 1'b1;
		cycles(8);
		chk(output_drive_en, 1'b0);
		over_temp   <= 1'b0;
		temp_cooled <= 1'b1;
		cycles(8);
		chk(output_drive_en, 1'b1);
		apb(8'h08, 1'b0, 32'h0, 33'h6);
		$display("end of thermal test");
		report_and_stop();
	end
endmodule : tb
